/* File: logic/switch_global_frame_control.sv */
`timescale 1ns/1ns
`include "gfc_consts.svh"
module switch_global_frame_control #(
  parameter int NUM_PORTS = 3,
  parameter int AGE_NORMAL_US = `AGE_NORMAL_S * `US_PER_S,
  parameter int AGE_FAST_US = `AGE_FAST_US
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register access
  input gfc_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // port status and frame boundary
  input wire logic [NUM_PORTS-1:0] LINK_UP,
  input wire logic FRAME_IDLE,
  // strap pins
  input wire logic MAC_MODE_STRAP_PIN,
  input wire logic SWITCH_MII_RX_BIT0_STRAP,
  // settings and aging events
  output gfc_pkg::policy_t POLICY,
  output logic AGE_PULSE,
  output logic FLUSH_ALL
);
  localparam int CYC_US = `CYC_PER_US;

  // refuse settings the counters cannot serve
  if (NUM_PORTS < 1 || AGE_FAST_US < 1 || AGE_NORMAL_US < AGE_FAST_US
      || CYC_US < 1 || CYC_US - 1 > 7'h7f
      || AGE_NORMAL_US > 28'hfff_ffff)
  begin : g_bad
    $error("switch_global_frame_control: bad parameters");
  end

  typedef struct packed {
    logic [7:0] ctl0_q;
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [7:0] app0_q;
    logic [7:0] app1_q;
    logic [7:0] app2_q;
    logic [7:0] rdata_q;
    logic [1:0] sync_a_q;
    logic [1:0] sync_b_q;
    logic [1:0] strap_cnt_q;
    logic [NUM_PORTS-1:0] link_q;
    logic [6:0] us_cnt_q;
    logic [27:0] age_cnt_q;
    logic fast_once_q;
    logic age_pulse_q;
    logic flush_q;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic us_tick;
  logic link_loss;
  logic [27:0] period;

  // register read decode, used by the read data path only
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input state_t s);
    case (a)
      `OFS_CTL0: read_reg = s.ctl0_q;
      `OFS_CTL1: read_reg = s.ctl1_q;
      `OFS_CTL2: read_reg = s.ctl2_q;
      default: read_reg = `RD_UNMAPPED;
    endcase
  endfunction

  // aging period; a pending link-loss pass runs fast once
  always_comb
  begin
    us_tick = (s_q.us_cnt_q == 7'(CYC_US - 1));
    link_loss = |(s_q.link_q & ~LINK_UP);
    if (s_q.app1_q[`B1_FAST_AGE] || s_q.fast_once_q)
    begin
      period = 28'(AGE_FAST_US);
    end
    else
    begin
      period = 28'(AGE_NORMAL_US);
    end
  end

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.age_pulse_q = 1'b0;
    s_d.flush_q = 1'b0;
    s_d.link_q = LINK_UP;
    // two-flop strap synchronisers
    s_d.sync_a_q = {SWITCH_MII_RX_BIT0_STRAP, MAC_MODE_STRAP_PIN};
    s_d.sync_b_q = s_q.sync_a_q;
    // register writes
    if (REG_REQ.wr)
    begin
      case (REG_REQ.addr)
        `OFS_CTL0: s_d.ctl0_q = REG_REQ.wdata;
        `OFS_CTL1: s_d.ctl1_q = REG_REQ.wdata;
        `OFS_CTL2: s_d.ctl2_q = REG_REQ.wdata;
        default: s_d.ctl0_q = s_q.ctl0_q;
      endcase
    end
    // straps are taken once the synchroniser has filled after reset
    if (s_q.strap_cnt_q != 2'h3)
    begin
      s_d.strap_cnt_q = s_q.strap_cnt_q + 2'h1;
    end
    if (s_q.strap_cnt_q == `STRAP_WAIT)
    begin
      s_d.ctl1_q[`B1_AGGR_BACKOFF] = s_q.sync_b_q[0];
      s_d.ctl2_q[`B2_KEEP_EXCESS] = s_q.sync_b_q[0];
      s_d.ctl2_q[`B2_LEGAL_MAX] = s_q.sync_b_q[1];
    end
    // settings pass to the ports only while no frame is in flight
    if (FRAME_IDLE)
    begin
      s_d.app0_q = s_d.ctl0_q;
      s_d.app1_q = s_d.ctl1_q;
      s_d.app2_q = s_d.ctl2_q;
    end
    // reads answer one cycle later
    if (REG_REQ.rd)
    begin
      s_d.rdata_q = read_reg(REG_REQ.addr, s_q);
    end
    // microsecond prescaler keeps the age counter narrow
    s_d.us_cnt_q = us_tick ? 7'h00 : s_q.us_cnt_q + 7'h01;
    if (!s_q.app1_q[`B1_AGE_EN])
    begin
      s_d.age_cnt_q = 28'h000_0000;
    end
    else if (us_tick)
    begin
      if (s_q.age_cnt_q >= period - 28'h000_0001)
      begin
        s_d.age_cnt_q = 28'h000_0000;
        s_d.age_pulse_q = 1'b1;
        s_d.fast_once_q = 1'b0;
      end
      else
      begin
        s_d.age_cnt_q = s_q.age_cnt_q + 28'h000_0001;
      end
    end
    // an unplugged port flushes the table at once
    if (link_loss)
    begin
      s_d.flush_q = 1'b1;
      if (s_q.app0_q[`B0_LINK_AGE])
      begin
        s_d.fast_once_q = 1'b1;
        s_d.age_cnt_q = 28'h000_0000;
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.ctl0_q <= `RST_CTL0;
      s_q.ctl1_q <= `RST_CTL1;
      s_q.ctl2_q <= `RST_CTL2;
      s_q.app0_q <= `RST_CTL0;
      s_q.app1_q <= `RST_CTL1;
      s_q.app2_q <= `RST_CTL2;
      // live link levels load here, so a port already down is no loss
      s_q.link_q <= LINK_UP;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // decoded settings from the applied copy; length field limit and excess collisions are fixed
  always_comb
  begin
    POLICY.pass_pause = s_q.app0_q[`B0_PASS_PAUSE];
    POLICY.buf_share = s_q.app0_q[`B0_BUF_SHARE];
    POLICY.buf_quota_thirds = s_q.app0_q[`B0_BUF_SHARE] ?
      `QUOTA_SHARED : `QUOTA_THIRD;
    // only meaningful with sniffer mode; debug use
    POLICY.pass_all = s_q.app1_q[`B1_PASS_ALL];
    POLICY.repeater = s_q.app1_q[`B1_REPEATER];
    POLICY.tx_pause = s_q.app1_q[`B1_TX_PAUSE];
    POLICY.rx_pause = s_q.app1_q[`B1_RX_PAUSE];
    POLICY.len_check = s_q.app1_q[`B1_LEN_CHECK];
    POLICY.len_field_limit = `LEN_FIELD_LIMIT;
    POLICY.aggr_backoff = s_q.app1_q[`B1_AGGR_BACKOFF];
    POLICY.vlan_discard = s_q.app2_q[`B2_VLAN_DISCARD];
    POLICY.mcast_excl = s_q.app2_q[`B2_MCAST_EXCL];
    POLICY.cs_backpress = s_q.app2_q[`B2_CS_BACKPRESS];
    POLICY.fair = s_q.app2_q[`B2_FAIR];
    POLICY.keep_excess = s_q.app2_q[`B2_KEEP_EXCESS];
    POLICY.excess_coll = `EXCESS_COLL;
    // huge support overrides the legal maximum bit
    if (s_q.app2_q[`B2_HUGE])
    begin
      POLICY.max_len_tagged = `LEN_HUGE;
      POLICY.max_len_untagged = `LEN_HUGE;
    end
    else if (s_q.app2_q[`B2_LEGAL_MAX])
    begin
      POLICY.max_len_tagged = `LEN_LEGAL_TAG;
      POLICY.max_len_untagged = `LEN_LEGAL_UNTAG;
    end
    else
    begin
      POLICY.max_len_tagged = `LEN_DEFAULT;
      POLICY.max_len_untagged = `LEN_DEFAULT;
    end
    POLICY.hp_reserve = s_q.app2_q[`B2_HP_RESERVE];
    POLICY.hp_bufs = s_q.app2_q[`B2_HP_RESERVE] ?
      `HP_RESERVE_BUFS : 6'h00;
  end

  // registered event and read outputs
  assign REG_RDATA = s_q.rdata_q;
  assign AGE_PULSE = s_q.age_pulse_q;
  assign FLUSH_ALL = s_q.flush_q;

  // checks on the whole block, all on the core clock
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // an idle edge leaves the applied copy equal to the live registers
  a_apply_idle: assert property (
    FRAME_IDLE |=> s_q.app0_q == s_q.ctl0_q && s_q.app1_q == s_q.ctl1_q
    && s_q.app2_q == s_q.ctl2_q) else $error("idle apply");
  // a frame in flight never sees its settings move
  a_hold_busy: assert property (
    !FRAME_IDLE |=> $stable(POLICY))
    else $error("setting changed mid-frame");
  // a write to control 2 lands unless the strap load takes that edge
  a_write_lands: assert property (
    REG_REQ.wr && REG_REQ.addr == `OFS_CTL2 &&
    s_q.strap_cnt_q != `STRAP_WAIT |=>
    s_q.ctl2_q == $past(REG_REQ.wdata)) else $error("write lost");

  // huge support overrides the legal maximum for both frame kinds
  a_huge_len: assert property (
    s_q.app2_q[`B2_HUGE] |-> POLICY.max_len_tagged == `LEN_HUGE &&
    POLICY.max_len_untagged == `LEN_HUGE) else $error("huge size");
  // legal maximum alone gives the tagged and untagged limits
  a_legal_len: assert property (
    !s_q.app2_q[`B2_HUGE] && s_q.app2_q[`B2_LEGAL_MAX] |->
    POLICY.max_len_tagged == `LEN_LEGAL_TAG &&
    POLICY.max_len_untagged == `LEN_LEGAL_UNTAG) else $error("legal size");

  // any port dropping its link flushes the table on the next edge
  a_flush_link: assert property (
    |($past(LINK_UP) & ~LINK_UP) |=> FLUSH_ALL)
    else $error("no flush on link loss");
  // a flush pulse always has a link loss behind it
  a_flush_cause: assert property (
    FLUSH_ALL |-> $past(link_loss)) else $error("flush without cause");

  // two cycles with aging off leave no pulse behind
  a_no_age_off: assert property (
    !s_q.app1_q[`B1_AGE_EN] [*2] |-> !AGE_PULSE)
    else $error("aged while disabled");
  // fast aging never pulses twice within a few cycles
  a_fast_gap: assert property (
    $rose(AGE_PULSE) && s_q.app1_q[`B1_FAST_AGE] && $stable(s_q.app1_q)
    |-> ##1 !AGE_PULSE [*8]) else $error("fast age too soon");

  // pause bits written while idle reach the ports on the next edge
  a_pause_map: assert property (
    REG_REQ.wr && REG_REQ.addr == `OFS_CTL1 && FRAME_IDLE |=>
    POLICY.tx_pause == $past(REG_REQ.wdata[`B1_TX_PAUSE]) &&
    POLICY.rx_pause == $past(REG_REQ.wdata[`B1_RX_PAUSE]))
    else $error("pause map");
  // a read of control 1 returns the live value one cycle later
  a_read_back: assert property (
    REG_REQ.rd && REG_REQ.addr == `OFS_CTL1 |=>
    REG_RDATA == $past(s_q.ctl1_q)) else $error("read back");

  // pins seen at the first edge after reset set the strapped defaults
  a_strap_load: assert property (
    s_q.strap_cnt_q == `STRAP_WAIT |=>
    s_q.ctl1_q[`B1_AGGR_BACKOFF] == $past(MAC_MODE_STRAP_PIN, 3) &&
    s_q.ctl2_q[`B2_KEEP_EXCESS] == $past(MAC_MODE_STRAP_PIN, 3) &&
    s_q.ctl2_q[`B2_LEGAL_MAX] == $past(SWITCH_MII_RX_BIT0_STRAP, 3))
    else $error("strap default");
  // sharing off caps each port at a third of the pool
  a_buf_quota: assert property (
    !POLICY.buf_share |-> POLICY.buf_quota_thirds == `QUOTA_THIRD)
    else $error("quota");
  // reserve on holds back the high-priority buffers
  a_hp_bufs: assert property (
    POLICY.hp_reserve |-> POLICY.hp_bufs == `HP_RESERVE_BUFS)
    else $error("priority buffers");

  // main scenarios
  c_flush: cover property (FLUSH_ALL);
  c_age: cover property (AGE_PULSE);
  c_huge: cover property (POLICY.max_len_tagged == `LEN_HUGE);
  c_wr_busy: cover property (REG_REQ.wr && !FRAME_IDLE);
  c_link_fast: cover property (s_q.fast_once_q ##1 AGE_PULSE);
endmodule // switch_global_frame_control

/* File: shared/gfc_consts.svh */
`ifndef GFC_CONSTS_SVH
`define GFC_CONSTS_SVH
// register offsets
`define OFS_CTL0 8'h02
`define OFS_CTL1 8'h03
`define OFS_CTL2 8'h04
// reset values, strap bits merged in later
`define RST_CTL0 8'h44
`define RST_CTL1 8'h34
`define RST_CTL2 8'hf1
`define RD_UNMAPPED 8'h00
// control 0 fields
`define B0_PASS_PAUSE 3
`define B0_BUF_SHARE 2
`define B0_LINK_AGE 0
// control 1 fields
`define B1_PASS_ALL 7
`define B1_REPEATER 6
`define B1_TX_PAUSE 5
`define B1_RX_PAUSE 4
`define B1_LEN_CHECK 3
`define B1_AGE_EN 2
`define B1_FAST_AGE 1
`define B1_AGGR_BACKOFF 0
// control 2 fields
`define B2_VLAN_DISCARD 7
`define B2_MCAST_EXCL 6
`define B2_CS_BACKPRESS 5
`define B2_FAIR 4
`define B2_KEEP_EXCESS 3
`define B2_HUGE 2
`define B2_LEGAL_MAX 1
`define B2_HP_RESERVE 0
// frame sizes and buffer figures
`define LEN_HUGE 11'h077c
`define LEN_DEFAULT 11'h0600
`define LEN_LEGAL_TAG 11'h05f2
`define LEN_LEGAL_UNTAG 11'h05ee
`define LEN_FIELD_LIMIT 11'h05dc
`define EXCESS_COLL 5'h10
`define HP_RESERVE_BUFS 6'h30
`define QUOTA_SHARED 2'h3
`define QUOTA_THIRD 2'h1
// timing
`define CLK_PERIOD_NS 10
`define NS_PER_US 1000
`define CYC_PER_US (`NS_PER_US / `CLK_PERIOD_NS)
`define AGE_NORMAL_S 200
`define AGE_FAST_US 800
`define US_PER_S 1000000
`define STRAP_WAIT 2'h2
`endif

/* File: shared/gfc_pkg.sv */
package gfc_pkg;
  // decoded frame handling settings, held steady across a frame
  typedef struct packed {
    logic pass_pause;
    logic buf_share;
    logic [1:0] buf_quota_thirds;
    logic pass_all;
    logic repeater;
    logic tx_pause;
    logic rx_pause;
    logic len_check;
    logic [10:0] len_field_limit;
    logic aggr_backoff;
    logic vlan_discard;
    logic mcast_excl;
    logic cs_backpress;
    logic fair;
    logic keep_excess;
    logic [4:0] excess_coll;
    logic [10:0] max_len_tagged;
    logic [10:0] max_len_untagged;
    logic hp_reserve;
    logic [5:0] hp_bufs;
  } policy_t;
  // register access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

/* File: tb/eth_link_partners.sv */
`timescale 1ns/1ns
module eth_link_partners (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic [2:0] unplug,
  input wire logic sending,
  // status seen by the switch
  output logic [2:0] link_up,
  output logic frame_idle
);
  // cables and frames change on the core clock, like a registered phy status
  always_ff @(posedge clk)
  begin
    link_up <= ~unplug;
    frame_idle <= ~sending;
  end
endmodule // eth_link_partners

/* File: tb/switch_global_frame_control_tb.sv */
`timescale 1ns/1ns
module switch_global_frame_control_tb;
  // stimulus and observed outputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  gfc_pkg::reg_req_t req = '0;
  logic [2:0] unplug = 3'h0;
  logic sending = 1'b0;
  logic strap_mac = 1'b1;
  logic strap_rx = 1'b0;
  logic [7:0] rdata;
  logic [2:0] link_up;
  logic frame_idle;
  logic age_pulse;
  logic flush_all;
  gfc_pkg::policy_t pol;
  int errors = 0;
  int n_tests = 0;
  int n;

  // 100 mhz core clock
  always #5 clk = ~clk;

  eth_link_partners u_eth_link_partners (.clk(clk), .unplug(unplug),
    .sending(sending), .link_up(link_up), .frame_idle(frame_idle));
  // short aging periods keep the run small: 20000 and 1000 cycles
  switch_global_frame_control #(.AGE_NORMAL_US(200), .AGE_FAST_US(10))
    u_switch_global_frame_control (.REF_CLK(clk), .RST(rst), .REG_REQ(req),
    .REG_RDATA(rdata), .LINK_UP(link_up), .FRAME_IDLE(frame_idle),
    .MAC_MODE_STRAP_PIN(strap_mac), .SWITCH_MII_RX_BIT0_STRAP(strap_rx),
    .POLICY(pol), .AGE_PULSE(age_pulse), .FLUSH_ALL(flush_all));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // compare helpers, one per result width
  task automatic chk_reg(input string w, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic chk_pol(input string w, input logic [10:0] e,
                         input logic [10:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask

  // register port: one-cycle strobes, data held with them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    #1 chk_reg("rdata", e, rdata);
  endtask

  // waits for an aging pulse, bounded; a miss ends the run
  task automatic wait_age(input int hi, output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      #1 c++;
    end while (age_pulse !== 1'b1 && c < hi);
    if (age_pulse !== 1'b1)
    begin
      errors++;
      $display("BAD age_pulse exp 1 got %b", age_pulse);
      finish_test();
    end
  endtask
  task automatic count_age(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1 if (age_pulse === 1'b1) c++;
    end
  endtask

  // defaults, straps mac=1 rx=0 merged in
  task automatic t_reset;
    rd(8'h02, 8'h44);
    rd(8'h03, 8'h35);
    rd(8'h04, 8'hf9);
    rd(8'h05, 8'h00);
    chk_pol("quota", 11'h3, 11'(pol.buf_quota_thirds));
    chk_pol("share", 11'h1, 11'(pol.buf_share));
    chk_pol("excess", 11'h10, 11'(pol.excess_coll));
    chk_pol("keep", 11'h1, 11'(pol.keep_excess));
    chk_pol("maxlen", 11'h600, pol.max_len_untagged);
    chk_pol("hpbufs", 11'h30, 11'(pol.hp_bufs));
    chk_pol("aggr", 11'h1, 11'(pol.aggr_backoff));
  endtask

  // every field except link aging and fast aging flipped away from its default
  task automatic t_fields;
    wr(8'h02, 8'h08);
    wr(8'h03, 8'hc8);
    wr(8'h04, 8'h06);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    rd(8'h04, 8'h06);
    chk_pol("passpause", 11'h1, 11'(pol.pass_pause));
    chk_pol("share", 11'h0, 11'(pol.buf_share));
    chk_pol("quota", 11'h1, 11'(pol.buf_quota_thirds));
    chk_pol("passall", 11'h1, 11'(pol.pass_all));
    chk_pol("repeat", 11'h1, 11'(pol.repeater));
    chk_pol("txpause", 11'h0, 11'(pol.tx_pause));
    chk_pol("rxpause", 11'h0, 11'(pol.rx_pause));
    chk_pol("lencheck", 11'h1, 11'(pol.len_check));
    chk_pol("lenlimit", 11'h5dc, pol.len_field_limit);
    chk_pol("vlan", 11'h0, 11'(pol.vlan_discard));
    chk_pol("mcast", 11'h0, 11'(pol.mcast_excl));
    chk_pol("cs", 11'h0, 11'(pol.cs_backpress));
    chk_pol("fair", 11'h0, 11'(pol.fair));
    chk_pol("keep", 11'h0, 11'(pol.keep_excess));
    chk_pol("hugelen", 11'h77c, pol.max_len_tagged);
    chk_pol("hp", 11'h0, 11'(pol.hp_reserve));
    chk_pol("hpoff", 11'h0, 11'(pol.hp_bufs));
    chk_pol("aggroff", 11'h0, 11'(pol.aggr_backoff));
    wr(8'h04, 8'h02);
    rd(8'h03, 8'hc8);
    chk_pol("tagged", 11'h5f2, pol.max_len_tagged);
    chk_pol("untagged", 11'h5ee, pol.max_len_untagged);
  endtask

  // a write during a frame waits for the gap
  task automatic t_frozen;
    sending <= 1'b1;
    repeat (2) @(posedge clk);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h04);
    chk_pol("busylen", 11'h5ee, pol.max_len_untagged);
    sending <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_pol("idlelen", 11'h77c, pol.max_len_untagged);
  endtask

  // aging off silences even fast aging; fast period 1000 cycles
  task automatic t_aging;
    wr(8'h03, 8'h02);
    count_age(2500, n);
    chk_pol("agedoff", 11'h0, 11'(n));
    wr(8'h03, 8'h06);
    wait_age(1200, n);
    wait_age(1200, n);
    chk_pol("fastgap", 11'h3e8, 11'(n));
  endtask

  // link loss: flush at once, one fast pass, then normal period
  task automatic t_link;
    wr(8'h03, 8'h04);
    wr(8'h02, 8'h01);
    repeat (3) @(posedge clk);
    unplug <= 3'h2;
    repeat (2) @(posedge clk);
    #1 chk_pol("flush", 11'h1, 11'(flush_all));
    @(posedge clk);
    #1 chk_pol("flushend", 11'h0, 11'(flush_all));
    wait_age(1100, n);
    count_age(1500, n);
    chk_pol("normal", 11'h0, 11'(n));
  endtask

  // a second reset with the straps flipped reloads their defaults
  task automatic t_straps;
    @(posedge clk);
    unplug <= 3'h0;
    strap_mac <= 1'b0;
    strap_rx <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    rd(8'h03, 8'h34);
    rd(8'h04, 8'hf3);
    chk_pol("aggr", 11'h0, 11'(pol.aggr_backoff));
    chk_pol("keep", 11'h0, 11'(pol.keep_excess));
    chk_pol("tagged", 11'h5f2, pol.max_len_tagged);
    chk_pol("untagged", 11'h5ee, pol.max_len_untagged);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_reset();
    t_fields();
    t_frozen();
    t_aging();
    t_link();
    t_straps();
    finish_test();
  end
endmodule // switch_global_frame_control_tb
